//--- src/cotc_host.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// R1: prescaler ratio changed only while prescaler halted
// R2: halt a timer before changing its source
// R3: halt a timer before reading its count
// R4: timer 1 reload write avoids underflow
// R5: timer 3 high reload write avoids underflow
// R6: timer 1 and carrier set before timer 3 runs
// R7: stop timer 3, then timer 1, carrier off; the code turns the carrier off first, then halts timer 3, then timer 1
// R8: device holds pin when auto-control cleared
// R9: device resumes gating at next timer 1 underflow
// R10: auto-control bit not toggled at underflow
// R11: auto-control uses carrier as timer 1 source; the code forces it only at source apply
// R12: no timer 1 reload load at count zero
// R13: carrier control is two bits, bit0 auto
// R14: device toggles gating on each timer 1 underflow; the model skips the first one after auto is set, which only arms
module cotc_host
   import cotc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [3:0] bus_addr,
   input wire logic [DW-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [DW-1:0] bus_rdata,
   output logic dev_strobe,
   output cotc_op_t dev_op,
   output logic [T1_W-1:0] dev_arg,
   input wire logic [T1_W-1:0] dev_rdata,
   input wire logic dev_t1_uf,
   input wire logic dev_t3_uf
);
   // all controller state
   typedef struct packed {
      cotc_state_t st;
      logic [2:0] step;
      logic [T1_W-1:0] t1_rl;
      logic [T3_W-1:0] t3_rh;
      logic [T3_W-1:0] t3_rl;
      logic [PRESC_W-1:0] presc;
      logic presc_run;
      logic [2:0] src;
      logic [C2_W-1:0] c2;
      logic [2:0] run;
      logic [1:0] rsel;
      logic [T1_W-1:0] count;
      logic err;
      cotc_op_t gop;
      cotc_cmd_t cmd;
      logic [DW-1:0] rdata;
   } cotc_hs_t;

   cotc_hs_t s_q, s_d;
   logic rst_sync_b; // released reset
   logic g_req; // guarded write waiting
   logic g_hazard; // underflow hazard for that write
   logic g_go; // guarded write may go
   logic busy; // a sequence is running
   logic sw_err; // refused software order this cycle
   logic [2:0] auto_src; // source bits with auto-control honoured

   cotc_rst_sync u_rst (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .rst_sync_b(rst_sync_b)
   );

   // hazard depends on which register the pending write targets
   always_comb begin
      g_req = (s_q.st == ST_GUARD);
      case (s_q.gop)
         OP_RELOAD1: g_hazard = dev_t1_uf; // see R4, see R12
         OP_CARRIER: g_hazard = dev_t1_uf; // see R10
         OP_RELOAD3H: g_hazard = dev_t3_uf; // see R5
         default: g_hazard = 1'b0;
      endcase
   end

   cotc_guard #(
      .QUIET(GUARD_QUIET)
   ) u_guard (
      .sys_clk(sys_clk),
      .rst_sync_b(rst_sync_b),
      .req(g_req),
      .hazard(g_hazard),
      .go(g_go)
   );

   assign busy = (s_q.st != ST_IDLE);
   // carrier clocks timer 1 from the next source apply while auto-control is on
   assign auto_src = s_q.c2[C2_AUTO] ? (s_q.src | 3'h1) : s_q.src; // see R11

   // next state: bus decode, then sequencer
   always_comb begin
      s_d = s_q;
      s_d.cmd = '0;
      s_d.cmd.op = OP_NONE;
      sw_err = 1'b0;

      // register reads answer one cycle later
      s_d.rdata = '0;
      if (bus_rd) begin
         case (bus_addr)
            ADR_CTRL: s_d.rdata = {24'h000000, s_q.presc_run, s_q.rsel,
                                   5'h00};
            ADR_T1_RELOAD: s_d.rdata = {22'h000000, s_q.t1_rl};
            ADR_T3_RELOAD_HIGH: s_d.rdata = {24'h000000, s_q.t3_rh};
            ADR_T3_RELOAD_LOW: s_d.rdata = {24'h000000, s_q.t3_rl};
            ADR_PRESC: s_d.rdata = {29'h00000000, s_q.presc};
            ADR_SRC: s_d.rdata = {29'h00000000, s_q.src};
            ADR_CARRIER_CTRL: s_d.rdata = {30'h00000000, s_q.c2};
            ADR_STATUS: s_d.rdata = {26'h0000000, s_q.presc_run,
                                     s_q.run, busy, s_q.err};
            ADR_COUNT: s_d.rdata = {22'h000000, s_q.count};
            default: s_d.rdata = '0; // unmapped reads zero
         endcase
      end

      // software writes; orders that find the sequencer busy are refused
      if (bus_wr) begin
         case (bus_addr)
            ADR_CTRL: begin
               if (busy) begin
                  sw_err = |bus_wdata[CTRL_READ:CTRL_START];
               end else if (bus_wdata[CTRL_START]) begin
                  // start only from fully halted timers
                  if (s_q.run[TMR1] || s_q.run[TMR3]) begin
                     sw_err = 1'b1;
                  end else begin
                     s_d.st = ST_START;
                     s_d.step = 3'h0;
                  end
               end else if (bus_wdata[CTRL_STOP]) begin
                  s_d.st = ST_STOP;
                  s_d.step = 3'h0;
               end else if (bus_wdata[CTRL_PRESC_APPLY]) begin
                  s_d.presc_run = bus_wdata[CTRL_PRESC_RUN];
                  s_d.st = ST_PRESC;
                  s_d.step = 3'h0;
               end else if (bus_wdata[CTRL_SRC_APPLY]) begin
                  s_d.st = ST_SRC;
                  s_d.step = 3'h0;
               end else if (bus_wdata[CTRL_READ]) begin
                  s_d.rsel = bus_wdata[CTRL_RSEL_LO+1:CTRL_RSEL_LO];
                  s_d.st = ST_READ;
                  s_d.step = 3'h0;
               end
            end
            ADR_T1_RELOAD: begin
               if (busy) begin
                  sw_err = 1'b1;
               end else begin
                  s_d.t1_rl = bus_wdata[T1_W-1:0];
                  // a running timer takes it through the guard
                  if (s_q.run[TMR1]) begin
                     s_d.st = ST_GUARD;
                     s_d.gop = OP_RELOAD1;
                  end
               end
            end
            ADR_T3_RELOAD_HIGH: begin
               if (busy) begin
                  sw_err = 1'b1;
               end else begin
                  s_d.t3_rh = bus_wdata[T3_W-1:0];
                  if (s_q.run[TMR3]) begin
                     s_d.st = ST_GUARD;
                     s_d.gop = OP_RELOAD3H;
                  end
               end
            end
            ADR_T3_RELOAD_LOW: begin
               if (busy) begin
                  sw_err = 1'b1;
               end else begin
                  s_d.t3_rl = bus_wdata[T3_W-1:0];
                  if (s_q.run[TMR3]) begin
                     s_d.st = ST_GUARD;
                     s_d.gop = OP_RELOAD3L;
                  end
               end
            end
            ADR_PRESC: begin
               // stored only; applied by the halting sequence
               if (busy) sw_err = 1'b1;
               else s_d.presc = bus_wdata[PRESC_W-1:0];
            end
            ADR_SRC: begin
               if (busy) sw_err = 1'b1;
               else s_d.src = bus_wdata[2:0];
            end
            ADR_CARRIER_CTRL: begin
               if (busy) begin
                  sw_err = 1'b1;
               end else begin
                  s_d.c2 = bus_wdata[C2_W-1:0]; // see R13
                  if (s_q.run[TMR1]) begin
                     s_d.st = ST_GUARD;
                     s_d.gop = OP_CARRIER;
                  end
               end
            end
            ADR_STATUS: begin
               if (bus_wdata[STAT_ERR]) s_d.err = 1'b0;
            end
            default: ; // unmapped writes are dropped
         endcase
      end

      // sequencer: at most one device command per step
      case (s_q.st)
         ST_IDLE: ;
         ST_PRESC: begin
            s_d.step = s_q.step + 3'h1;
            case (s_q.step)
               3'h0: begin
                  // halt first so the ratio never changes under count
                  s_d.cmd = '{1'b1, OP_PRESC_RUN, 10'h000}; // see R1
               end
               3'h1: begin
                  s_d.cmd = '{1'b1, OP_PRESC_RATIO, {7'h00, s_q.presc}};
               end
               default: begin
                  s_d.cmd = '{1'b1, OP_PRESC_RUN, {9'h000, s_q.presc_run}};
                  s_d.st = ST_IDLE;
               end
            endcase
         end
         ST_SRC: begin
            s_d.step = s_q.step + 3'h1;
            if (s_q.step == 3'h0) begin
               // timers stay halted; software restarts them
               s_d.cmd = '{1'b1, OP_RUN, 10'h000}; // see R2
               s_d.run = 3'h0;
            end else begin
               s_d.cmd = '{1'b1, OP_SRC, {7'h00, auto_src}}; // see R11
               s_d.st = ST_IDLE;
            end
         end
         ST_READ: begin
            s_d.step = s_q.step + 3'h1;
            case (s_q.step)
               3'h0: begin
                  // freeze the chosen timer before sampling it
                  s_d.cmd = '{1'b1, OP_RUN,
                     {7'h00, s_q.run & ~(3'h1 << s_q.rsel)}}; // see R3
               end
               3'h1: s_d.cmd = '{1'b1, OP_READ, {8'h00, s_q.rsel}};
               3'h2: s_d.count = dev_rdata; // answer stands this cycle
               default: begin
                  s_d.cmd = '{1'b1, OP_RUN, {7'h00, s_q.run}};
                  s_d.st = ST_IDLE;
               end
            endcase
         end
         ST_START: begin
            // timer 3 is the last thing switched on
            s_d.step = s_q.step + 3'h1;
            case (s_q.step)
               3'h0: s_d.cmd = '{1'b1, OP_RELOAD1, s_q.t1_rl}; // see R6
               3'h1: s_d.cmd = '{1'b1, OP_RELOAD3H, {2'h0, s_q.t3_rh}};
               3'h2: s_d.cmd = '{1'b1, OP_RELOAD3L, {2'h0, s_q.t3_rl}};
               3'h3: s_d.cmd = '{1'b1, OP_CARRIER, {8'h00, s_q.c2}};
               3'h4: begin
                  s_d.cmd = '{1'b1, OP_RUN, {7'h00, s_q.run | 3'h1}};
                  s_d.run[TMR1] = 1'b1;
               end
               default: begin
                  s_d.cmd = '{1'b1, OP_RUN, {7'h00, s_q.run | 3'h4}};
                  s_d.run[TMR3] = 1'b1; // see R6
                  s_d.st = ST_IDLE;
               end
            endcase
         end
         ST_STOP: begin
            case (s_q.step)
               3'h0: begin
                  // carrier off, held until no timer 1 underflow near
                  if (!dev_t1_uf) begin
                     s_d.c2[C2_AUTO] = 1'b0;
                     s_d.cmd = '{1'b1, OP_CARRIER,
                        {8'h00, s_q.c2[1], 1'b0}}; // see R7, see R10
                     s_d.step = 3'h1;
                  end
               end
               3'h1: begin
                  s_d.cmd = '{1'b1, OP_RUN, {7'h00, s_q.run & 3'h3}};
                  s_d.run[TMR3] = 1'b0; // see R7
                  s_d.step = 3'h2;
               end
               default: begin
                  s_d.cmd = '{1'b1, OP_RUN, {7'h00, s_q.run & 3'h2}};
                  s_d.run[TMR1] = 1'b0; // see R7
                  s_d.st = ST_IDLE;
               end
            endcase
         end
         ST_GUARD: begin
            // single write to a running timer, clear of underflow except the timer 3 low reload
            if (g_go) begin
               case (s_q.gop)
                  OP_RELOAD1: s_d.cmd = '{1'b1, OP_RELOAD1, s_q.t1_rl};
                  OP_RELOAD3H: begin
                     s_d.cmd = '{1'b1, OP_RELOAD3H, {2'h0, s_q.t3_rh}};
                  end
                  OP_RELOAD3L: begin
                     s_d.cmd = '{1'b1, OP_RELOAD3L, {2'h0, s_q.t3_rl}};
                  end
                  default: s_d.cmd = '{1'b1, OP_CARRIER, {8'h00, s_q.c2}};
               endcase
               s_d.st = ST_IDLE;
            end
         end
         default: s_d.st = ST_IDLE; // illegal code recovers
      endcase

      // a refusal in the clearing cycle still sets the flag
      if (sw_err) s_d.err = 1'b1;
   end

   // one register for all state
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_q.st <= ST_IDLE;
         s_q.step <= 3'h0;
         s_q.t1_rl <= T1_RELOAD_RST;
         s_q.t3_rh <= T3_RELOAD_RST;
         s_q.t3_rl <= T3_RELOAD_RST;
         s_q.presc <= PRESC_RST;
         s_q.presc_run <= 1'b0;
         s_q.src <= SRC_RST;
         s_q.c2 <= C2_RST;
         s_q.run <= 3'h0;
         s_q.rsel <= 2'h0;
         s_q.count <= 10'h000;
         s_q.err <= 1'b0;
         s_q.gop <= OP_NONE;
         s_q.cmd <= '0;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // device pins straight from flip-flops
   assign dev_strobe = s_q.cmd.strobe;
   assign dev_op = s_q.cmd.op;
   assign dev_arg = s_q.cmd.arg;
   assign bus_rdata = s_q.rdata;
endmodule // cotc_host

//--- src/cotc_pkg.sv
package cotc_pkg;
   // register word addresses of the controller's own port
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_T1_RELOAD = 4'h1;
   localparam logic [3:0] ADR_T3_RELOAD_HIGH = 4'h2;
   localparam logic [3:0] ADR_T3_RELOAD_LOW = 4'h3;
   localparam logic [3:0] ADR_PRESC = 4'h4;
   localparam logic [3:0] ADR_SRC = 4'h5;
   localparam logic [3:0] ADR_CARRIER_CTRL = 4'h6;
   localparam logic [3:0] ADR_STATUS = 4'h7;
   localparam logic [3:0] ADR_COUNT = 4'h8;
   // control word fields
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_PRESC_APPLY = 2;
   localparam int CTRL_SRC_APPLY = 3;
   localparam int CTRL_READ = 4;
   localparam int CTRL_RSEL_LO = 5;
   localparam int CTRL_PRESC_RUN = 7;
   // status word fields
   localparam int STAT_ERR = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_RUN_LO = 2;
   localparam int STAT_PRUN = 5;
   // run / source bit positions per timer
   localparam int TMR1 = 0;
   localparam int TMR3 = 2;
   // carrier control register: bit 0 = auto-control enable
   localparam int C2_AUTO = 0;
   localparam int C2_W = 2;
   // widths
   localparam int T1_W = 10;
   localparam int T3_W = 8;
   localparam int PRESC_W = 3;
   localparam int DW = 32;
   // reset values
   localparam logic [T1_W-1:0] T1_RELOAD_RST = 10'h000;
   localparam logic [T3_W-1:0] T3_RELOAD_RST = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_RST = 3'h0;
   localparam logic [2:0] SRC_RST = 3'h0;
   localparam logic [C2_W-1:0] C2_RST = 2'h0;
   // quiet cycles demanded before a guarded write is let through
   localparam int GUARD_QUIET = 1;

   // device command opcodes on the command pins
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_PRESC_RUN = 4'h1,
      OP_PRESC_RATIO = 4'h2,
      OP_SRC = 4'h3,
      OP_RUN = 4'h4,
      OP_RELOAD1 = 4'h5,
      OP_RELOAD3H = 4'h6,
      OP_RELOAD3L = 4'h7,
      OP_CARRIER = 4'h8,
      OP_READ = 4'h9
   } cotc_op_t;

   // sequencer states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_PRESC = 7'h02,
      ST_SRC = 7'h04,
      ST_READ = 7'h08,
      ST_START = 7'h10,
      ST_STOP = 7'h20,
      ST_GUARD = 7'h40
   } cotc_state_t;

   // one command toward the device
   typedef struct packed {
      logic strobe;
      cotc_op_t op;
      logic [T1_W-1:0] arg;
   } cotc_cmd_t;

   // software register port
   typedef struct packed {
      logic [3:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } cotc_bus_t;
endpackage

//--- src/cotc_rst_sync.sv
`timescale 1ns/1ps
module cotc_rst_sync (
   input wire logic sys_clk,
   input wire logic rst_b,
   output logic rst_sync_b
);
   // two-stage release; the first stage feeds only the second
   typedef struct packed {
      logic s1;
      logic s2;
   } cotc_rs_t;
   cotc_rs_t s_q, s_d;

   // next value: shift a one in
   always_comb begin
      s_d = s_q;
      s_d.s1 = 1'b1;
      s_d.s2 = s_q.s1;
   end

   // assertion is immediate, release is clocked
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rst_sync_b = s_q.s2;
endmodule // cotc_rst_sync

//--- src/cotc_guard.sv
`timescale 1ns/1ps
module cotc_guard #(
   parameter int QUIET = 1
) (
   input wire logic sys_clk,
   input wire logic rst_sync_b,
   input wire logic req,
   input wire logic hazard,
   output logic go
);
   // counts cycles with the hazard low; saturates at QUIET
   typedef struct packed {
      logic [7:0] quiet;
   } cotc_gs_t;
   cotc_gs_t g_q, g_d;

   // hazard or an idle guard restarts the count, so none is stale
   always_comb begin
      g_d = g_q;
      if (hazard || !req) begin
         g_d.quiet = 8'h00;
      end else if (g_q.quiet < 8'(QUIET)) begin
         g_d.quiet = g_q.quiet + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         g_q <= '0;
      end else begin
         g_q <= g_d;
      end
   end

   // released only when quiet long enough and still quiet now
   assign go = req && !hazard && (g_q.quiet >= 8'(QUIET));
endmodule // cotc_guard

//--- sim/cotc_host_asserts.sv
`timescale 1ns/1ps
module cotc_host_asserts
   import cotc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [3:0] bus_addr,
   input wire logic [DW-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [DW-1:0] bus_rdata,
   input wire logic dev_strobe,
   input wire cotc_op_t dev_op,
   input wire logic [T1_W-1:0] dev_arg,
   input wire logic [T1_W-1:0] dev_rdata,
   input wire logic dev_t1_uf,
   input wire logic dev_t3_uf
);
   // shadow of the last commanded run and auto bits
   logic [2:0] run_q;
   logic auto_q;
   logic run_cmd;
   assign run_cmd = dev_strobe && dev_op == OP_RUN;
   // follows the command lines only, so a lost command shows up below
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 3'h0;
         auto_q <= 1'b0;
      end else if (run_cmd) begin
         run_q <= dev_arg[2:0];
      end else if (dev_strobe && dev_op == OP_CARRIER) begin
         auto_q <= dev_arg[C2_AUTO];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // carrier off, then timer 3 halted with timer 1 still running
   sequence s_stop_head;
      dev_strobe && dev_op == OP_CARRIER && !dev_arg[C2_AUTO] && run_q[TMR3]
      ##1 run_cmd && !dev_arg[TMR3] && dev_arg[TMR1];
   endsequence
   chk_cmd_idle:
      assert property (!dev_strobe |-> dev_op == OP_NONE && dev_arg == 10'h000)
      else $error("command lines not idle");
   chk_reset_quiet:
      assert property ($rose(rst_b) |-> !dev_strobe ##1 !dev_strobe)
      else $error("command right after reset");
   chk_rdata_idle:
      assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
      else $error("read data outside its cycle");
   chk_presc_halt:
      assert property (dev_strobe && dev_op == OP_PRESC_RATIO |->
         $past(dev_strobe) && $past(dev_op) == OP_PRESC_RUN && !$past(dev_arg[0]))
      else $error("ratio changed with prescaler running");
   chk_src_halt:
      assert property (dev_strobe && dev_op == OP_SRC |->
         $past(run_cmd) && $past(dev_arg[2:0]) == 3'h0)
      else $error("source changed with timers running");
   chk_src_auto:
      assert property (dev_strobe && dev_op == OP_SRC && auto_q |-> dev_arg[TMR1])
      else $error("timer 1 not on carrier under auto");
   chk_read_halt:
      assert property (dev_strobe && dev_op == OP_READ |-> $past(run_cmd) &&
         (($past(dev_arg[2:0]) >> dev_arg[1:0]) & 3'h1) == 3'h0)
      else $error("count read from a running timer");
   chk_reload1_gap:
      assert property (dev_strobe && dev_op == OP_RELOAD1 && run_q[TMR1] |->
         !$past(dev_t1_uf) && !$past(dev_t1_uf, 2))
      else $error("timer 1 reload at underflow");
   chk_reload3_gap:
      assert property (dev_strobe && dev_op == OP_RELOAD3H && run_q[TMR3] |->
         !$past(dev_t3_uf) && !$past(dev_t3_uf, 2))
      else $error("timer 3 high reload at underflow");
   chk_auto_gap:
      assert property (dev_strobe && dev_op == OP_CARRIER && run_q[TMR1] |->
         !$past(dev_t1_uf))
      else $error("auto bit changed at underflow");
   chk_t3_start:
      assert property (run_cmd && dev_arg[TMR3] && !run_q[TMR3] &&
         $past(dev_op) != OP_READ && $past(dev_op, 2) != OP_READ |->
         run_q[TMR1] && $past(dev_op, 2) == OP_CARRIER)
      else $error("timer 3 started before setup");
   chk_stop_order:
      assert property (s_stop_head |=> run_cmd && dev_arg[2:0] == 3'h0)
      else $error("stop sequence out of order");
endmodule // cotc_host_asserts

bind cotc_host cotc_host_asserts cotc_host_asserts_inst (
   .sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .dev_strobe(dev_strobe), .dev_op(dev_op),
   .dev_arg(dev_arg), .dev_rdata(dev_rdata), .dev_t1_uf(dev_t1_uf),
   .dev_t3_uf(dev_t3_uf)
);

//--- sim/cotc_dev_model.sv
`timescale 1ns/1ps
module cotc_dev_model
   import cotc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic dev_strobe,
   input wire cotc_op_t dev_op,
   input wire logic [T1_W-1:0] dev_arg,
   output logic [T1_W-1:0] dev_rdata,
   output logic dev_t1_uf,
   output logic dev_t3_uf,
   output logic modulated_output_pin
);
   logic [2:0] run_q, src_q;
   logic [PRESC_W-1:0] presc_q;
   logic prun_q, wave_q, gate_q, arm_q;
   logic [C2_W-1:0] c2_q; // two bits only
   logic [T1_W-1:0] rl1_q, cnt1_q, rd_q;
   logic [T3_W-1:0] rh_q, rl_q, cnt3_q;
   logic t1_z, t3_z; // underflow at the end of this cycle
   logic [T1_W-1:0] rd_now; // count of the selected timer
   // prescaler not modelled: timers count every clock to keep runs short
   assign t1_z = run_q[TMR1] && cnt1_q == 10'h000;
   assign t3_z = run_q[TMR3] && cnt3_q == 8'h00;
   // hazard pins rise one cycle ahead of the underflow itself
   assign dev_t1_uf = run_q[TMR1] && cnt1_q == 10'h001;
   assign dev_t3_uf = run_q[TMR3] && cnt3_q == 8'h01;
   assign rd_now = dev_arg[1:0] == 2'h0 ? cnt1_q :
      dev_arg[1:0] == 2'h2 ? {2'h0, cnt3_q} : 10'h000;
   // answer stands in the strobe cycle; idle lines show the inverse
   assign dev_rdata = (dev_strobe && dev_op == OP_READ) ? rd_now : ~rd_q;
   // counters, carrier wave, gating and command decode
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         {run_q, src_q, presc_q, prun_q, wave_q, gate_q, arm_q} <= '0;
         {c2_q, rl1_q, cnt1_q, rd_q, rh_q, rl_q, cnt3_q} <= '0;
         modulated_output_pin <= 1'b0;
      end else begin
         if (run_q[TMR1]) cnt1_q <= t1_z ? rl1_q : cnt1_q - 10'h001;
         if (t3_z) begin
            wave_q <= ~wave_q;
            cnt3_q <= wave_q ? rl_q : rh_q;
         end else if (run_q[TMR3]) begin
            cnt3_q <= cnt3_q - 8'h01;
         end
         // first underflow after enabling only arms the gate
         if (t1_z && c2_q[C2_AUTO]) begin
            gate_q <= gate_q ^ arm_q;
            arm_q <= 1'b1;
         end
         // pin holds its level while auto is off or not yet armed
         if (c2_q[C2_AUTO] && arm_q) begin
            modulated_output_pin <= gate_q & wave_q;
         end
         if (dev_strobe) begin
            case (dev_op)
               OP_PRESC_RUN: prun_q <= dev_arg[0];
               OP_PRESC_RATIO: presc_q <= dev_arg[PRESC_W-1:0];
               OP_SRC: src_q <= dev_arg[2:0];
               OP_RUN: run_q <= dev_arg[2:0];
               OP_RELOAD1: rl1_q <= dev_arg;
               OP_RELOAD3H: rh_q <= dev_arg[T3_W-1:0];
               OP_RELOAD3L: rl_q <= dev_arg[T3_W-1:0];
               OP_CARRIER: begin
                  c2_q <= dev_arg[C2_W-1:0];
                  if (!dev_arg[C2_AUTO]) arm_q <= 1'b0;
               end
               OP_READ: rd_q <= rd_now;
               default: ;
            endcase
         end
      end
   end
endmodule // cotc_dev_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
   import cotc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] bus_addr = 4'h0;
   logic [DW-1:0] bus_wdata = 32'h0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [DW-1:0] bus_rdata, rv, pin_was;
   logic dev_strobe, dev_t1_uf, dev_t3_uf, mod_pin;
   cotc_op_t dev_op;
   logic [T1_W-1:0] dev_arg, dev_rdata;
   int num_errors = 0;
   int check_count = 0;
   // readback masks of registers 1 to 6
   localparam logic [DW-1:0] MSK [1:6] =
      '{32'h3FF, 32'hFF, 32'hFF, 32'h7, 32'h7, 32'h3};
   always #20 sys_clk = ~sys_clk;
   cotc_host cotc_host_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .dev_strobe(dev_strobe),
      .dev_op(dev_op), .dev_arg(dev_arg), .dev_rdata(dev_rdata),
      .dev_t1_uf(dev_t1_uf), .dev_t3_uf(dev_t3_uf));
   cotc_dev_model cotc_dev_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .dev_strobe(dev_strobe), .dev_op(dev_op), .dev_arg(dev_arg),
      .dev_rdata(dev_rdata), .dev_t1_uf(dev_t1_uf),
      .dev_t3_uf(dev_t3_uf), .modulated_output_pin(mod_pin));
   // verdict and end of run
   task summarize;
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [DW-1:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   // data stand in the cycle after the strobe
   task rd(input logic [3:0] a);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 rv = bus_rdata;
   endtask
   // poll busy; a stuck sequencer ends the run
   task idle;
      for (int i = 0; i < 200; i++) begin
         rd(ADR_STATUS);
         if (rv[STAT_BUSY] === 1'b0) return;
      end
      num_errors++;
      $display("MISMATCH %0t busy never cleared", $time);
      summarize;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int a = 0; a < 16; a++) begin
         rd(4'(a));
         check(rv, 32'h0);
      end
      for (int a = 1; a < 7; a++) begin
         wr(4'(a), 32'hFFFF_FFFF);
         rd(4'(a));
         check(rv, MSK[a]);
      end
      wr(ADR_T1_RELOAD, 32'h5);
      wr(ADR_T3_RELOAD_HIGH, 32'h3);
      wr(ADR_T3_RELOAD_LOW, 32'h2);
      wr(ADR_CARRIER_CTRL, 32'h1);
      wr(ADR_CTRL, 32'h1);
      idle;
      check(rv, 32'h14);
      check(32'(cotc_dev_model_inst.rl1_q), 32'h5);
      // start while running is refused, then err cleared
      wr(ADR_CTRL, 32'h1);
      idle;
      check(rv, 32'h15);
      wr(ADR_STATUS, 32'h1);
      rd(ADR_STATUS);
      check(rv, 32'h14);
      // reloads while counting wait for a quiet moment
      wr(ADR_T1_RELOAD, 32'h7);
      idle;
      wr(ADR_T3_RELOAD_HIGH, 32'h4);
      idle;
      check(32'(cotc_dev_model_inst.rl1_q), 32'h7);
      check(32'(cotc_dev_model_inst.rh_q), 32'h4);
      // halted count reads of timer 1 and timer 3
      for (int s = 0; s < 3; s += 2) begin
         wr(ADR_CTRL, 32'h10 | 32'(s << 5));
         idle;
         check(rv, 32'h14);
         rd(ADR_COUNT);
         check(rv, 32'(cotc_dev_model_inst.rd_q));
      end
      // auto off mid-run: pin must stay put
      wr(ADR_CARRIER_CTRL, 32'h0);
      idle;
      check(32'(cotc_dev_model_inst.c2_q), 32'h0);
      pin_was = 32'(mod_pin);
      repeat (30) @(posedge sys_clk);
      check(32'(mod_pin), pin_was);
      wr(ADR_CARRIER_CTRL, 32'h1);
      idle;
      wr(ADR_PRESC, 32'h3);
      wr(ADR_CTRL, 32'h84);
      idle;
      check(rv, 32'h34);
      check(32'(cotc_dev_model_inst.presc_q), 32'h3);
      // source apply halts all; timer 1 forced onto the carrier
      wr(ADR_SRC, 32'h2);
      wr(ADR_CTRL, 32'h8);
      idle;
      check(rv, 32'h20);
      check(32'(cotc_dev_model_inst.src_q), 32'h3);
      wr(ADR_CTRL, 32'h1);
      idle;
      wr(ADR_CTRL, 32'h2);
      idle;
      check(rv, 32'h20);
      check(32'(cotc_dev_model_inst.c2_q), 32'h0);
      // order taken while busy is dropped
      wr(ADR_CTRL, 32'h1);
      wr(ADR_T1_RELOAD, 32'h9);
      idle;
      check(rv, 32'h35);
      rd(ADR_T1_RELOAD);
      check(rv, 32'h7);
      summarize;
   end
   // watchdog on the whole run
   initial begin
      repeat (50000) @(posedge sys_clk);
      num_errors++;
      summarize;
   end
endmodule // tb
